// [lcsd_driver.sv]
// Common-row scan driver: pin sampling, 120-stage chain and level selection.
`timescale 1ns/10ps
module lcsd_driver #(
   parameter int         STAGES    = lcsd_pkg::STAGES,
   parameter logic [7:0] LEVEL_MAP = lcsd_pkg::LEVEL_MAP_DEFAULT
) (
   // Clock and reset.
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   // Controller pins.
   input  wire logic                 scan_shift_clock,
   input  wire logic                 ac_phase,
   input  wire logic                 split_mode_select,
   input  wire logic                 shift_direction_select,
   input  wire logic                 split_data_in,
   input  wire logic                 blank_n,
   // Cascade ports.
   input  wire logic                 cascade_port_a_in,
   output logic                      cascade_port_a_out,
   output logic                      cascade_port_a_oe,
   input  wire logic                 cascade_port_b_in,
   output logic                      cascade_port_b_out,
   output logic                      cascade_port_b_oe,
   // Row drive select codes, two bits per row.
   output logic [2*STAGES-1:0]       row_drive_out,
   // Falling scan clock edge dropped because the event FIFO was full.
   output logic                      shift_overrun
);
   localparam int HALF = STAGES / 2;
   initial begin
      if (STAGES != lcsd_pkg::STAGES) $error("STAGES must be 120");
   end

   // Level code from phase and stage bit.
   function automatic logic [1:0] pick_level(input logic ph, input logic bit_v);
      logic [2:0] idx;
      idx = {ph, bit_v, 1'b0};
      return LEVEL_MAP[idx +: 2]; // R9 R10 R11 R15
   endfunction

   typedef struct packed {
      lcsd_pkg::lcsd_pins_type  s1;
      lcsd_pkg::lcsd_pins_type  s2;
      lcsd_pkg::lcsd_pins_type  s3;
      lcsd_pkg::lcsd_pins_type  pin;
      logic [STAGES-1:0]        chain;
      logic                     a_out;
      logic                     b_out;
      logic                     a_oe;
      logic                     b_oe;
      logic [2*STAGES-1:0]      drive;
      logic                     overrun;
   } lcsd_state_type;

   lcsd_state_type          st;
   lcsd_state_type          next_st;
   lcsd_pkg::lcsd_pins_type raw;
   logic                    fall_ev;
   logic                    ev_ready;
   logic                    ev_valid;
   lcsd_pkg::lcsd_pins_type ev;

   always_comb begin
      raw                        = '0;
      raw.scan_shift_clock       = scan_shift_clock;
      raw.ac_phase               = ac_phase;
      raw.split_mode_select      = split_mode_select;
      raw.shift_direction_select = shift_direction_select;
      raw.cascade_port_a         = cascade_port_a_in;
      raw.cascade_port_b         = cascade_port_b_in;
      raw.split_data_in          = split_data_in;
      raw.blank_n                = blank_n;
   end

   // A falling edge, captured with the data valid at that edge, enters the FIFO.
   assign fall_ev = st.pin.scan_shift_clock && (st.s2.scan_shift_clock == st.s3.scan_shift_clock)
                    && !st.s3.scan_shift_clock;

   lcsd_fifo #(
      .WIDTH ($bits(lcsd_pkg::lcsd_pins_type)),
      .DEPTH (lcsd_pkg::FIFO_DEPTH)
   ) u_events (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (fall_ev),
      .in_ready  (ev_ready),
      .in_data   (st.s3),
      .out_valid (ev_valid),
      .out_ready (1'b1),
      .out_data  (ev)
   );

   always_comb begin
      logic dir;
      logic split;
      logic in_main;
      dir        = 1'b0;
      split      = 1'b0;
      in_main    = 1'b0;
      next_st    = st;
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Each pin updates only once the second and third stages agree.
      for (int i = 0; i < $bits(lcsd_pkg::lcsd_pins_type); i++) begin
         if (st.s2[i] == st.s3[i]) next_st.pin[i] = st.s3[i];
      end
      next_st.overrun = fall_ev && !ev_ready;
      dir   = st.pin.shift_direction_select;
      split = st.pin.split_mode_select;
      next_st.a_oe = !dir; // R3 R4
      next_st.b_oe = dir; // R3 R4
      if (ev_valid) begin
         dir     = ev.shift_direction_select;
         split   = ev.split_mode_select;
         in_main = dir ? ev.cascade_port_a : ev.cascade_port_b;
         if (dir) begin
            // Index 0 is stage 1; data runs upward and leaves from stage 120.
            next_st.b_out = st.chain[STAGES-1]; // R2 R3
            next_st.chain = {st.chain[STAGES-2:0], in_main}; // R1 R3 R12
            if (split) begin
               next_st.chain[HALF] = ev.split_data_in; // R6 R7 R14
            end
         end else begin
            next_st.a_out = st.chain[0]; // R2 R4
            next_st.chain = {in_main, st.chain[STAGES-1:1]}; // R1 R4 R12
            if (split) begin
               next_st.chain[HALF-1] = ev.split_data_in; // R6 R7 R14
            end
         end
      end
      for (int n = 0; n < STAGES; n++) begin
         next_st.drive[2*n +: 2] = st.pin.blank_n
            ? pick_level(st.pin.ac_phase, next_st.chain[n]) // R5 R9 R11
            : lcsd_pkg::LVL_BLANK; // R8
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign cascade_port_a_out = st.a_out;
   assign cascade_port_a_oe  = st.a_oe;
   assign cascade_port_b_out = st.b_out;
   assign cascade_port_b_oe  = st.b_oe;
   assign row_drive_out      = st.drive;
   assign shift_overrun      = st.overrun;

   // Blanking overrides every row on the very next edge.
   a_blank_forces_low: assert property (@(posedge clock) disable iff (!rst_n) // R8
      !st.pin.blank_n
      |=> row_drive_out == {STAGES{lcsd_pkg::LVL_BLANK}})
      else $error("blank did not force lowest level");

   // The enables follow the filtered direction one edge late, not during reset.
   a_port_dir_oe: assert property (@(posedge clock) disable iff (!rst_n) // R3
      $past(rst_n) && $past(st.pin.shift_direction_select)
      |-> cascade_port_b_oe && !cascade_port_a_oe)
      else $error("cascade enables wrong for direction");

   // Downward direction drives port a and releases port b.
   a_port_dir_oe_low: assert property (@(posedge clock) disable iff (!rst_n) // R4
      $past(rst_n) && !$past(st.pin.shift_direction_select)
      |-> cascade_port_a_oe && !cascade_port_b_oe)
      else $error("cascade enables wrong for downward direction");

   // A whole chain moves upward by one stage per event.
   a_shift_up: assert property (@(posedge clock) disable iff (!rst_n) // R1
      ev_valid && ev.shift_direction_select && !ev.split_mode_select
      |=> st.chain[STAGES-1:1] == $past(st.chain[STAGES-2:0]))
      else $error("chain did not advance upward");

   // Split upward: each half moves on its own, nothing crosses from 60 to 61.
   a_shift_up_split: assert property (@(posedge clock) disable iff (!rst_n) // R14
      ev_valid && ev.shift_direction_select && ev.split_mode_select
      |=> st.chain[HALF-1:1] == $past(st.chain[HALF-2:0]) && st.chain[STAGES-1:HALF+1] == $past(st.chain[STAGES-2:HALF]))
      else $error("split halves did not advance upward");

   // A whole chain moves downward by one stage per event.
   a_shift_down: assert property (@(posedge clock) disable iff (!rst_n) // R4
      ev_valid && !ev.shift_direction_select && !ev.split_mode_select
      |=> st.chain[STAGES-2:0] == $past(st.chain[STAGES-1:1]))
      else $error("chain did not advance downward");

   // Split downward: each half moves on its own, nothing crosses from 61 to 60.
   a_shift_down_split: assert property (@(posedge clock) disable iff (!rst_n) // R6
      ev_valid && !ev.shift_direction_select && ev.split_mode_select
      |=> st.chain[HALF-2:0] == $past(st.chain[HALF-1:1]) && st.chain[STAGES-2:HALF] == $past(st.chain[STAGES-1:HALF+1]))
      else $error("split halves did not advance downward");

   // Upward shifts take the new bit from port a into stage 1.
   a_in_main_up: assert property (@(posedge clock) disable iff (!rst_n) // R3
      ev_valid && ev.shift_direction_select
      |=> st.chain[0] == $past(ev.cascade_port_a))
      else $error("port a bit not in stage 1");

   // Downward shifts take the new bit from port b into stage 120.
   a_in_main_down: assert property (@(posedge clock) disable iff (!rst_n) // R4
      ev_valid && !ev.shift_direction_select
      |=> st.chain[STAGES-1] == $past(ev.cascade_port_b))
      else $error("port b bit not in stage 120");

   // Split upward: the split input lands in stage 61.
   a_split_feed: assert property (@(posedge clock) disable iff (!rst_n) // R7
      ev_valid && ev.split_mode_select && ev.shift_direction_select
      |=> st.chain[HALF] == $past(ev.split_data_in))
      else $error("split input not at stage 61");

   // Split downward: the split input lands in stage 60.
   a_split_feed_down: assert property (@(posedge clock) disable iff (!rst_n) // R7
      ev_valid && ev.split_mode_select && !ev.shift_direction_select
      |=> st.chain[HALF-1] == $past(ev.split_data_in))
      else $error("split input not at stage 60");

   // The bit leaving stage 120 appears on port b with the same event.
   a_out_bit_up: assert property (@(posedge clock) disable iff (!rst_n) // R2
      ev_valid && ev.shift_direction_select
      |=> cascade_port_b_out == $past(st.chain[STAGES-1]))
      else $error("last stage not presented on port b");

   // The bit leaving stage 1 appears on port a with the same event.
   a_out_bit_down: assert property (@(posedge clock) disable iff (!rst_n) // R2
      ev_valid && !ev.shift_direction_select
      |=> cascade_port_a_out == $past(st.chain[0]))
      else $error("first stage not presented on port a");

   // Port b keeps its bit until the next upward event.
   a_out_hold_b: assert property (@(posedge clock) disable iff (!rst_n) // R2
      !(ev_valid && ev.shift_direction_select)
      |=> $stable(cascade_port_b_out))
      else $error("port b changed without an upward shift");

   // Port a keeps its bit until the next downward event.
   a_out_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // R2
      !(ev_valid && !ev.shift_direction_select)
      |=> $stable(cascade_port_a_out))
      else $error("port a changed without a downward shift");

   // Without an event the chain must not move at all.
   a_hold_idle: assert property (@(posedge clock) disable iff (!rst_n) // R1
      !ev_valid
      |=> $stable(st.chain))
      else $error("chain moved without a clock pulse");

   // Row 1 follows stage 1 and the phase.
   a_level_map: assert property (@(posedge clock) disable iff (!rst_n) // R9
      st.pin.blank_n
      |=> row_drive_out[1:0] == pick_level($past(st.pin.ac_phase), st.chain[0]))
      else $error("row 1 level mismatch");

   // Row 120 follows stage 120 and the phase.
   a_level_map_last: assert property (@(posedge clock) disable iff (!rst_n) // R5
      st.pin.blank_n
      |=> row_drive_out[2*STAGES-1 -: 2] == pick_level($past(st.pin.ac_phase), st.chain[STAGES-1]))
      else $error("row 120 level mismatch");

   // Row 60 follows stage 60, the last stage of the lower half.
   a_level_map_mid: assert property (@(posedge clock) disable iff (!rst_n) // R5
      st.pin.blank_n
      |=> row_drive_out[2*HALF-1 -: 2] == pick_level($past(st.pin.ac_phase), st.chain[HALF-1]))
      else $error("row 60 level mismatch");

   // Row 61 follows stage 61, the first stage of the upper half.
   a_level_map_upper: assert property (@(posedge clock) disable iff (!rst_n) // R11
      st.pin.blank_n
      |=> row_drive_out[2*HALF+1 -: 2] == pick_level($past(st.pin.ac_phase), st.chain[HALF]))
      else $error("row 61 level mismatch");

   // Exactly one cascade port drives once the enables have left reset.
   a_oe_exclusive: assert property (@(posedge clock) disable iff (!rst_n) // R12
      $past(rst_n)
      |-> cascade_port_a_oe != cascade_port_b_oe)
      else $error("cascade enables not exclusive");

   // A fall that finds the event queue full is reported, never silently lost.
   a_overrun_pulse: assert property (@(posedge clock) disable iff (!rst_n) // R1
      fall_ev && !ev_ready
      |=> shift_overrun)
      else $error("lost shift not reported");

   // The overrun flag never rises without a lost fall.
   a_overrun_quiet: assert property (@(posedge clock) disable iff (!rst_n) // R1
      !(fall_ev && !ev_ready)
      |=> !shift_overrun)
      else $error("overrun reported without a lost shift");

   // One falling scan clock edge yields one event only.
   a_fall_once: assert property (@(posedge clock) disable iff (!rst_n) // R2
      fall_ev
      |=> !fall_ev)
      else $error("one fall produced two events");

   // The filtered scan clock takes a level once two sync stages agree.
   a_pin_filter: assert property (@(posedge clock) disable iff (!rst_n) // R2
      st.s2.scan_shift_clock == st.s3.scan_shift_clock
      |=> st.pin.scan_shift_clock == $past(st.s3.scan_shift_clock))
      else $error("filtered scan clock missed a settled level");

   // While the sync stages disagree the filtered scan clock holds.
   a_pin_hold: assert property (@(posedge clock) disable iff (!rst_n) // R2
      st.s2.scan_shift_clock != st.s3.scan_shift_clock
      |=> $stable(st.pin.scan_shift_clock))
      else $error("filtered scan clock moved on a glitch");

   // An accepted fall is offered to the chain on the next edge.
   a_drain_next: assert property (@(posedge clock) disable iff (!rst_n) // R1
      fall_ev && ev_ready
      |=> ev_valid)
      else $error("queued shift not delivered");
endmodule

// [lcsd_pkg.sv]
// Constants and types shared by the common-row scan driver.
// Operation
// R1: The driver holds a 120-stage scan chain that moves one stage per scan shift clock pulse.
// R2: On each falling scan clock edge a new bit enters and the end-stage bit leaves on the out port.
// R3: With direction select high, port a is input, port b output, data moves stage 1 up to 120.
// R4: With direction select low, port b is input, port a output, data moves stage 120 down to 1.
// R5: Stage n steers row output n.
// R6: Split mode high runs two 60-stage halves, low runs one 120-stage chain.
// R7: In split mode the split data input feeds 61..120 when direction is high, 60..1 when low.
// R8: While blank_n is low every output shows the lowest level; outputs run normally only when high.
// R9: Each output picks one of four levels from the AC phase and its stage bit.
// R10: Two levels are selected-row levels and two are non-selected-row levels.
// R11: Toggling the AC phase alternates the polarity of every output's level.
// R12: The direction select sets both shift direction and row scan order.
// R13: The controller holds blank_n low at least one frame after power-up while it initialises.
// R14: In split mode the cascade input feeds the other half and the chain breaks between 60 and 61.
// R15: Each output level is a two-bit code whose mapping from phase and bit is a parameter.
package lcsd_pkg;
   localparam int          STAGES     = 120;
   localparam int          HALF       = 60;
   localparam int          SYNC_DEPTH = 3;
   localparam int          FIFO_DEPTH = 32;
   localparam logic [1:0]  LVL_SEL_HI = 2'h0;
   localparam logic [1:0]  LVL_SEL_LO = 2'h1;
   localparam logic [1:0]  LVL_UNS_LO = 2'h2;
   localparam logic [1:0]  LVL_UNS_HI = 2'h3;
   // Index is {ac_phase, stage_bit}; the lowest level doubles as the blank level.
   localparam logic [7:0]  LEVEL_MAP_DEFAULT = {LVL_SEL_LO, LVL_UNS_LO, LVL_SEL_HI, LVL_UNS_HI};
   localparam logic [1:0]  LVL_BLANK  = LVL_SEL_LO;

   typedef struct packed {
      logic scan_shift_clock;
      logic ac_phase;
      logic split_mode_select;
      logic shift_direction_select;
      logic cascade_port_a;
      logic cascade_port_b;
      logic split_data_in;
      logic blank_n;
   } lcsd_pins_type;
endpackage

// [lcsd_fifo.sv]
// Parameterised valid/ready FIFO carrying scan words.
`timescale 1ns/10ps
module lcsd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Fill side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } lcsd_fptr_type;
   lcsd_fptr_type           st;
   lcsd_fptr_type           next_st;
   logic [WIDTH-1:0]        mem [DEPTH];
   logic                    do_wr;
   logic                    do_rd;

   assign in_ready  = (st.wr - st.rd) != (AW+1)'(DEPTH);
   assign out_valid = st.wr != st.rd;
   assign out_data  = mem[st.rd[AW-1:0]];
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (do_wr) next_st.wr = st.wr + 1'b1;
      if (do_rd) next_st.rd = st.rd + 1'b1;
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
      if (do_wr) mem[st.wr[AW-1:0]] <= in_data;
   end
endmodule

// [lcsd_ctrl_model.sv]
// Controller model: scan clock pulses and power-up blanking.
`timescale 1ns/10ps
module lcsd_ctrl_model (
   // Clock and requests.
   input  wire logic clock,
   input  wire logic go,
   input  wire logic blank_req,
   // Pins and completion.
   output logic      scan_shift_clock,
   output logic      blank_n,
   output logic      done
);
   int pulses;
   int cnt;
   initial begin
      pulses = 0;
      cnt = 0;
      scan_shift_clock = 1'b0;
      done = 1'b0;
   end
   // The clock idles low between pulses; each pulse is far slower than the sync filter.
   always @(negedge clock) begin
      done <= (cnt == 16);
      scan_shift_clock <= (cnt >= 1 && cnt <= 4);
      if (cnt == 5)
         pulses <= pulses + 1;
      if (cnt == 0)
         cnt <= go ? 1 : 0;
      else
         cnt <= (cnt == 16) ? 0 : cnt + 1;
   end
   // The display stays blanked until a full frame of shifts has initialised the chain.
   assign blank_n = (pulses >= 120) && blank_req;
endmodule

// [testbench.sv]
// Self-checking testbench for the common-row scan driver.
`timescale 1ns/10ps
module testbench;
   logic clock, rst_n, go, bchk, blk, cpa, cpb, sdi, ph, split, dir, scl, bln, done;
   logic a_out, a_oe, b_out, b_oe, ovr;
   logic [239:0] rows;
   logic [119:0] sr;
   logic sout;
   logic [244:0] q[$];
   int mismatches, n_checks;
   wire a_wire = a_oe ? a_out : cpa;
   wire b_wire = b_oe ? b_out : cpb;
   lcsd_ctrl_model i_ctrl (.clock(clock), .go(go), .blank_req(blk), .scan_shift_clock(scl),
      .blank_n(bln), .done(done));
   lcsd_driver i_dut (.clock(clock), .rst_n(rst_n), .scan_shift_clock(scl), .ac_phase(ph),
      .split_mode_select(split), .shift_direction_select(dir), .split_data_in(sdi),
      .blank_n(bln), .cascade_port_a_in(a_wire), .cascade_port_a_out(a_out),
      .cascade_port_a_oe(a_oe), .cascade_port_b_in(b_wire), .cascade_port_b_out(b_out),
      .cascade_port_b_oe(b_oe), .row_drive_out(rows), .shift_overrun(ovr));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   function automatic logic [244:0] expv(input logic p, input logic bl);
      logic [239:0] r;
      for (int i = 0; i < 120; i++)
         r[2*i+:2] = bl ? lcsd_pkg::LEVEL_MAP_DEFAULT[2*int'({p, sr[i]})+:2] : lcsd_pkg::LVL_BLANK;
      return {1'b0, !dir, dir, sout, r};
   endfunction
   task automatic check(input string what, input logic [244:0] seen, input logic [244:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   always @(posedge clock)
      if ((done === 1'b1 || bchk) && q.size() > 0)
         check("outputs", {ovr, a_oe, b_oe, dir ? b_out : a_out, rows}, q.pop_front());
   task automatic shift(input bit keep);
      logic a, b, d, p;
      a = 1'($urandom);
      b = 1'($urandom);
      d = 1'($urandom);
      p = 1'($urandom);
      cpa <= a;
      cpb <= b;
      sdi <= d;
      ph <= p;
      go <= 1'b1;
      sout = dir ? sr[119] : sr[0];
      if (dir)
         sr = split ? {sr[118:60], d, sr[58:0], a} : {sr[118:0], a};
      else
         sr = split ? {b, sr[119:61], d, sr[59:1]} : {b, sr[119:1]};
      if (keep)
         q.push_back(expv(p, blk));
      @(negedge clock);
      go <= 1'b0;
      repeat (20) @(negedge clock);
   endtask
   task automatic pins(input logic p, input logic bl);
      ph <= p;
      blk <= bl;
      repeat (10) @(negedge clock);
      q.push_back(expv(p, bl));
      bchk <= 1'b1;
      @(negedge clock);
      bchk <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #(50 * 20000);
      mismatches++;
      end_of_test();
   end
   initial begin
      {rst_n, go, bchk, blk, cpa, cpb, sdi, ph, split} = '0;
      dir = 1'b1;
      sr = '0;
      sout = 1'b0;
      mismatches = 0;
      n_checks = 0;
      void'($urandom(32'hB4A3));
      repeat (16) @(negedge clock);
      rst_n <= 1'b1;
      repeat (8) @(negedge clock);
      // The first frame fills every stage so that later expectations are fully known.
      for (int i = 0; i < 120; i++)
         shift(1'b0);
      pins(ph, 1'b0);
      for (int m = 0; m < 4; m++) begin
         split <= m[1];
         dir <= m[0];
         blk <= 1'b1;
         repeat (10) @(negedge clock);
         for (int j = 0; j < 30; j++)
            shift(1'b1);
         pins(~ph, 1'b1);
         pins(ph, 1'b0);
         $display("test mode %0d done", m);
      end
      end_of_test();
   end
endmodule
